// ---- core/malt_hash.sv ----
// Hash of MAC address and filter identifier into a bucket index
`timescale 1ns/1ps
module malt_hash (
  // Key in, bucket out
  malt_hash_if.hasher hif
);
  logic [59:0] wide;
  logic [9:0]  fold;

  // Fold the key in 10-bit slices; option picks the final mix
  always_comb begin
    wide = {2'h0, hif.filter_identifier & {7{hif.use_fid}}, 3'h0, hif.mac};
    fold = 10'h000;
    for (int i = 0; i < 6; i++) begin
      fold = fold ^ wide[i*10 +: 10];
    end
    unique case (hif.opt)
      2'h1:    hif.bucket = {fold[4:0], fold[9:5]} ^ hif.mac[47:38];
      2'h2:    hif.bucket = hif.mac[9:0] ^ wide[57:48];
      default: hif.bucket = fold;
    endcase
  end
endmodule : malt_hash

// ---- core/malt_hash_if.sv ----
// Key and bucket index between the table and its hash unit
`timescale 1ns/1ps
interface malt_hash_if;
  logic [47:0] mac;
  logic [6:0]  filter_identifier;
  logic        use_fid;
  logic [1:0]  opt;
  logic [9:0]  bucket;
  modport user   (output mac, filter_identifier, use_fid, opt, input bucket);
  modport hasher (input mac, filter_identifier, use_fid, opt, output bucket);
endinterface : malt_hash_if

// ---- core/malt_pkg.sv ----
// Shared constants, codes and entry layout of the MAC address lookup table
package malt_pkg;
  // Table geometry
  localparam int unsigned WAYS    = 4;
  localparam int unsigned BUCKETS = 1024;
  localparam int unsigned ENTRIES = WAYS * BUCKETS;
  localparam logic [11:0] LAST_ENTRY = 12'hfff;

  // Register byte addresses
  localparam logic [15:0] OFF_CTRL = 16'h0400;
  localparam logic [15:0] OFF_IDX0 = 16'h0410;
  localparam logic [15:0] OFF_IDX1 = 16'h0414;
  localparam logic [15:0] OFF_ACC  = 16'h0418;
  localparam logic [15:0] OFF_ENT1 = 16'h0420;
  localparam logic [15:0] OFF_ENT2 = 16'h0424;
  localparam logic [15:0] OFF_ENT3 = 16'h0428;
  localparam logic [15:0] OFF_ENT4 = 16'h042c;
  localparam logic [15:0] OFF_EVT  = 16'h0430;

  // Access control fields
  localparam int unsigned ACC_GO     = 31;
  localparam int unsigned ACC_DIRECT = 3;

  // Event bits
  localparam int unsigned EVT_AF = 0;
  localparam int unsigned EVT_WF = 1;
  localparam int unsigned EVT_LF = 2;

  // Age value loaded on learning or access
  localparam logic [2:0] AGE_RELOAD = 3'h7;
  localparam logic [2:0] FULL_WAYS  = 3'h4;

  // Table operation codes
  typedef enum logic [1:0] {
    OP_NONE   = 2'b00,
    OP_WRITE  = 2'b01,
    OP_READ   = 2'b10,
    OP_SEARCH = 2'b11
  } malt_op_t;

  // One stored table entry
  typedef struct packed {
    logic        valid;
    logic        stat;
    logic        sfilt;
    logic        dfilt;
    logic [2:0]  age;
    logic [2:0]  mstp;
    logic [6:0]  ports;
    logic [6:0]  filter_identifier;
    logic [47:0] mac;
  } malt_ent_t;
endpackage : malt_pkg

// ---- core/malt_table.sv ----
// MAC address lookup table: storage, ingress lookup, learning, aging, host access
// Operation
// - DA lookups merge all tables; SA lookups learn, age and migrate here only.
// - Static DA result beats a dynamic DA result.
// - Aging never touches static entries.
// - Storage is 1K buckets of 4 ways, 4K entries.
// - Key hashes to a 10-bit bucket; ways not addressable by hash.
// - Fill a free way, else replace least recently used dynamic way.
// - Static add to bucket with 2-3 statics flags almost full, latches address.
// - Static add to 4-static bucket fails, flags, latches bucket index.
// - Learning into 4-static bucket fails, flags, latches bucket in index 1.
// - Host may read any entry but writes only static entries.
// - Host hashed access shares the ingress hash unit and its option.
// - Host methods: hashed, direct, read-only sequential search.
// - Host reaches the table only through index, control and entry registers.
// - Operation code 01 writes, 10 reads, 11 searches.
// - Go/done clears on completion; after a read, valid tells whether found.
// - Search skips invalid entries, resumes after entry 4 read, stops on clear.
`timescale 1ns/1ps
module malt_table
  import malt_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Lookup request from ingress
  input  wire logic        lk_valid,
  output logic             lk_ready,
  input  wire logic        lk_src,
  input  wire logic [47:0] lk_mac,
  input  wire logic [6:0]  lk_fid,
  input  wire logic [2:0]  lk_port,
  // Results of the other address tables
  input  wire logic        sta_hit,
  input  wire logic [6:0]  sta_ports,
  input  wire logic        rsv_hit,
  input  wire logic [6:0]  rsv_ports,
  // Aging period tick
  input  wire logic        age_tick,
  // Lookup result
  output logic             res_valid,
  output logic             res_hit,
  output logic             res_static,
  output logic             res_drop,
  output logic [6:0]       res_ports
);
  typedef enum logic [2:0] {S_INIT, S_IDLE, S_LOOK, S_HOST, S_SRCH, S_SWAIT, S_AGE} malt_st_t;

  typedef struct packed {
    malt_st_t     st;
    logic         go;
    logic         valid;
    malt_op_t     op;
    logic         direct;
    logic [12:0]  vcnt;
    logic [31:0]  idx0;
    logic [31:0]  idx1;
    logic [127:0] ents;
    logic [1:0]   hopt;
    logic         use_fid;
    logic         age_en;
    logic [2:0]   evt;
    logic [11:0]  ptr;
    logic [47:0]  kmac;
    logic [6:0]   kfid;
    logic         ksa;
    logic [2:0]   kport;
    logic         ksta;
    logic [6:0]   ksports;
    logic         krsv;
    logic [6:0]   krports;
    logic         age_pend;
    logic         rvalid;
    logic         rhit;
    logic         rstat;
    logic         rdrop;
    logic [6:0]   rports;
  } malt_state_t;

  malt_state_t r;
  malt_state_t n;
  malt_ent_t   mem [ENTRIES];
  malt_ent_t   way [WAYS];
  malt_ent_t   dent;
  malt_ent_t   pent;
  malt_ent_t   ent_in;
  malt_ent_t   mem_data;
  logic [11:0] mem_addr;
  logic        mem_we;
  logic [3:0]  mt;
  logic [3:0]  stw;
  logic [9:0]  bucket;
  logic [2:0]  nstat;
  logic [1:0]  mi;
  logic [1:0]  vic;
  logic        hit;
  logic        has_vic;
  logic [2:0]  best;
  logic        wr;
  logic        rd4;
  logic        stop;
  logic [2:0]  evt_set;
  logic [2:0]  evt_clr;

  // Register file image of an entry; an invalid entry reads as zeros
  function automatic logic [127:0] to_regs(malt_ent_t e);
    to_regs = {e.stat, e.sfilt, e.dfilt, e.age, 23'h0, e.mstp, 25'h0, e.ports,
               9'h0, e.filter_identifier, e.mac} & {128{e.valid}};
  endfunction : to_regs

  // Shared hash, keyed from the latched request of either source
  malt_hash_if hif ();
  malt_hash u_hash (.hif(hif));
  assign hif.mac     = r.kmac;
  assign hif.filter_identifier     = r.kfid;
  assign hif.use_fid = r.use_fid;
  assign hif.opt     = r.hopt;
  assign bucket      = hif.bucket;

  // Four ways of the addressed bucket and their match flags
  for (genvar w = 0; w < WAYS; w++) begin : g_way
    assign way[w] = mem[{bucket, 2'(w)}];
    assign mt[w]  = way[w].valid && way[w].mac == r.kmac &&
                    (!r.use_fid || way[w].filter_identifier == r.kfid);
    assign stw[w] = way[w].valid && way[w].stat;
  end
  assign dent = mem[r.idx0[11:0]];
  assign pent = mem[r.ptr];
  assign hit  = |mt;

  // Matching way, static count, and the replacement victim
  always_comb begin
    mi      = 2'h0;
    nstat   = 3'h0;
    vic     = 2'h0;
    has_vic = 1'b0;
    best    = 3'h7;
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (mt[w]) begin
        mi = 2'(w);
      end
      nstat = nstat + {2'h0, stw[w]};
    end
    // Free way first, then the stalest dynamic way by age count
    for (int w = 0; w < WAYS; w++) begin
      if (!way[w].valid && !has_vic) begin
        vic     = 2'(w);
        has_vic = 1'b1;
      end
    end
    for (int w = 0; w < WAYS; w++) begin
      if (!has_vic && way[w].valid && !way[w].stat && way[w].age <= best) begin
        if (!(way[w].age == best && best != 3'h7)) begin
          vic  = 2'(w);
          best = way[w].age;
        end
      end
    end
    if (best != 3'h7 || (!has_vic && nstat != FULL_WAYS)) begin
      has_vic = 1'b1;
    end
  end

  // Entry image from the entry registers, for host writes
  always_comb begin
    ent_in       = '0;
    ent_in.valid = 1'b1;
    ent_in.stat  = r.ents[127];
    ent_in.sfilt = r.ents[126];
    ent_in.dfilt = r.ents[125];
    ent_in.age   = r.ents[124:122];
    ent_in.mstp  = r.ents[98:96];
    ent_in.ports = r.ents[70:64];
    ent_in.filter_identifier   = r.ents[54:48];
    ent_in.mac   = r.ents[47:0];
  end

  // APB strobes; zero-wait slave
  assign wr      = psel && penable && pwrite;
  assign rd4     = psel && penable && !pwrite && paddr == OFF_ENT4;
  assign stop    = wr && paddr == OFF_ACC && r.go && !pwdata[ACC_GO];
  assign evt_clr = (wr && paddr == OFF_EVT) ? pwdata[2:0] : 3'h0;
  assign pready  = 1'b1;

  // Read mux; unmapped addresses answer with an error and zero data
  always_comb begin
    pslverr = 1'b0;
    unique case (paddr)
      OFF_CTRL: prdata = {28'h0, r.age_en, r.use_fid, r.hopt};
      OFF_IDX0: prdata = r.idx0;
      OFF_IDX1: prdata = r.idx1;
      OFF_ACC:  prdata = {r.go, r.valid, r.valid | ~r.go, r.vcnt, 12'h0, r.direct, 1'b0, r.op};
      OFF_ENT1: prdata = r.ents[127:96];
      OFF_ENT2: prdata = r.ents[95:64];
      OFF_ENT3: prdata = r.ents[63:32];
      OFF_ENT4: prdata = r.ents[31:0];
      OFF_EVT:  prdata = {29'h0, r.evt};
      default: begin
        prdata  = 32'h0000_0000;
        pslverr = psel && penable;
      end
    endcase
  end

  // Next state: register writes, then the table engine
  always_comb begin
    n        = r;
    n.rvalid = 1'b0;
    mem_we   = 1'b0;
    mem_addr = r.ptr;
    mem_data = '0;
    evt_set  = 3'h0;
    // Host registers; index, entry and access registers frozen while an operation runs except a go clear, control always writable
    if (wr) begin
      unique case (paddr)
        OFF_CTRL: {n.age_en, n.use_fid, n.hopt} = pwdata[3:0];
        OFF_IDX0: if (!r.go) n.idx0 = pwdata;
        OFF_IDX1: if (!r.go) n.idx1 = pwdata;
        OFF_ENT1: if (!r.go) n.ents[127:96] = pwdata;
        OFF_ENT2: if (!r.go) n.ents[95:64] = pwdata;
        OFF_ENT3: if (!r.go) n.ents[63:32] = pwdata;
        OFF_ENT4: if (!r.go) n.ents[31:0] = pwdata;
        OFF_ACC: begin
          if (!r.go) begin
            n.go     = pwdata[ACC_GO];
            n.direct = pwdata[ACC_DIRECT];
            n.op     = malt_op_t'(pwdata[1:0]);
            if (pwdata[ACC_GO]) begin
              n.valid = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    if (age_tick && r.age_en && r.st != S_IDLE) begin
      n.age_pend = 1'b1;
    end
    unique case (r.st)
      // Clear every way once after reset
      S_INIT: begin
        mem_we = 1'b1;
        n.ptr  = r.ptr + 12'h1;
        if (r.ptr == LAST_ENTRY) n.st = S_IDLE;
      end
      // Ingress first unless host is waiting, then host, then aging
      S_IDLE: begin
        if (lk_valid && !r.go) begin
          n.kmac    = lk_mac;
          n.kfid    = lk_fid;
          n.ksa     = lk_src;
          n.kport   = lk_port;
          n.ksta    = sta_hit;
          n.ksports = sta_ports;
          n.krsv    = rsv_hit;
          n.krports = rsv_ports;
          n.st      = S_LOOK;
        end else if (r.go) begin
          n.kmac = {r.idx1[15:0], r.idx0};
          n.kfid = r.idx1[22:16];
          n.ptr  = 12'h000;
          n.vcnt = 13'h0000;
          unique case (r.op)
            OP_SEARCH:       n.st = S_SRCH;
            OP_READ, OP_WRITE: n.st = S_HOST;
            OP_NONE:         n.go = 1'b0;
          endcase
        end else if ((age_tick || r.age_pend) && r.age_en) begin
          n.ptr      = 12'h000;
          n.age_pend = 1'b0;
          n.st       = S_AGE;
        end
      end
      // One lookup per request; the bucket is ready one cycle after the key
      S_LOOK: begin
        n.rvalid   = 1'b1;
        n.st       = S_IDLE;
        n.rhit     = hit;
        n.rstat    = hit && way[mi].stat;
        n.rports   = hit ? way[mi].ports : 7'h00;
        mem_addr   = {bucket, mi};
        mem_data   = way[mi];
        mem_data.age = AGE_RELOAD;
        if (!r.ksa) begin
          n.rdrop = hit && way[mi].dfilt;
          mem_we  = hit && !way[mi].stat;
          if (r.krsv) begin
            {n.rhit, n.rstat, n.rports} = {2'b11, r.krports};
          end else if (!(hit && way[mi].stat) && r.ksta) begin
            {n.rhit, n.rstat, n.rports} = {2'b11, r.ksports};
          end
        end else begin
          n.rdrop = hit && way[mi].sfilt;
          if (hit) begin
            // Refresh and migrate a dynamic entry to the arrival port
            mem_we         = !way[mi].stat;
            mem_data.ports = 7'(8'h01 << r.kport);
          end else if (nstat == FULL_WAYS) begin
            evt_set[EVT_LF] = 1'b1;
            n.idx1[9:0]     = bucket;
          end else if (has_vic) begin
            mem_we   = 1'b1;
            mem_addr = {bucket, vic};
            mem_data = '0;
            mem_data.valid = 1'b1;
            mem_data.age   = AGE_RELOAD;
            mem_data.ports = 7'(8'h01 << r.kport);
            mem_data.filter_identifier   = r.kfid;
            mem_data.mac   = r.kmac;
          end
        end
      end
      // Single-cycle hashed or direct host read and write
      S_HOST: begin
        n.go     = 1'b0;
        n.st     = S_IDLE;
        mem_data = ent_in;
        if (r.op == OP_READ) begin
          n.valid = r.direct ? dent.valid : hit;
          n.ents  = r.direct ? to_regs(dent) : (hit ? to_regs(way[mi]) : 128'h0);
        end else if (ent_in.stat) begin
          if (r.direct) begin
            mem_we   = 1'b1;
            mem_addr = r.idx0[11:0];
          end else if (hit) begin
            mem_we   = 1'b1;
            mem_addr = {bucket, mi};
          end else if (nstat == FULL_WAYS) begin
            evt_set[EVT_WF] = 1'b1;
            n.idx0[9:0]     = bucket;
          end else begin
            mem_we   = 1'b1;
            mem_addr = {bucket, vic};
            if (nstat >= 3'h2) begin
              evt_set[EVT_AF] = 1'b1;
              n.idx0[11:0]    = {bucket, vic};
            end
          end
        end
      end
      // Walk the table one entry a cycle, skipping invalid ones
      S_SRCH: begin
        if (pent.valid) begin
          n.ents  = to_regs(pent);
          n.valid = 1'b1;
          n.vcnt  = r.vcnt + 13'h0001;
          n.st    = S_SWAIT;
        end else if (r.ptr == LAST_ENTRY) begin
          n.go   = 1'b0;
          n.ents = 128'h0;
          n.st   = S_IDLE;
        end else begin
          n.ptr = r.ptr + 12'h1;
        end
      end
      // Hold the found entry until software has read its last word
      S_SWAIT: begin
        if (rd4) begin
          n.valid = 1'b0;
          if (r.ptr == LAST_ENTRY) begin
            n.go   = 1'b0;
            n.ents = 128'h0;
            n.st   = S_IDLE;
          end else begin
            n.ptr = r.ptr + 12'h1;
            n.st  = S_SRCH;
          end
        end
      end
      // Age dynamic entries; statics are left alone
      S_AGE: begin
        mem_data = pent;
        if (pent.valid && !pent.stat) begin
          mem_we         = 1'b1;
          mem_data.age   = pent.age - 3'h1;
          mem_data.valid = pent.age > 3'h1;
        end
        n.ptr = r.ptr + 12'h1;
        if (r.ptr == LAST_ENTRY) n.st = S_IDLE;
      end
    endcase
    // Search abort by clearing go/done
    if (stop) begin
      n.go = 1'b0;
      n.st = S_IDLE;
    end
    // Sticky events; a new event wins over a same-cycle clear
    n.evt = (r.evt & ~evt_clr) | evt_set;
  end

  // State register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Table array, no reset: swept clear in S_INIT
  always_ff @(posedge clk_sys) begin
    if (mem_we) mem[mem_addr] <= mem_data;
  end

  assign lk_ready   = r.st == S_IDLE && !r.go;
  assign res_valid  = r.rvalid;
  assign res_hit    = r.rhit;
  assign res_static = r.rstat;
  assign res_drop   = r.rdrop;
  assign res_ports  = r.rports;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  AST_DA_RSV: assert property (lk_valid && lk_ready && !lk_src && rsv_hit |-> ##2
    res_valid && res_ports == $past(rsv_ports, 2)) else $error("reserved DA result lost");
  AST_STATIC_WINS: assert property (lk_valid && lk_ready && !lk_src && sta_hit |-> ##2
    res_valid && res_static && res_hit) else $error("static DA result not preferred");
  AST_NO_STATIC_AGE: assert property (r.st == S_AGE && pent.stat |-> !mem_we)
    else $error("aging wrote a static entry");
  AST_BUCKET: assert property (r.st == S_LOOK && mem_we |-> mem_addr[11:2] == bucket)
    else $error("learning outside hashed bucket");
  AST_ALMOST_FULL: assert property (r.st == S_HOST && !r.direct && r.op == OP_WRITE &&
    r.ents[127] && !hit && nstat inside {3'h2, 3'h3} |-> mem_we ##1
    r.evt[EVT_AF] && r.idx0[11:0] == $past(mem_addr)) else $error("almost full missed");
  AST_WRITE_FAIL: assert property (r.st == S_HOST && !r.direct && r.op == OP_WRITE &&
    r.ents[127] && !hit && nstat == FULL_WAYS |-> !mem_we ##1
    r.evt[EVT_WF] && r.idx0[9:0] == $past(bucket)) else $error("write fail missed");
  AST_LEARN_FAIL: assert property (r.st == S_LOOK && r.ksa && !hit &&
    nstat == FULL_WAYS |=> r.evt[EVT_LF] && r.idx1[9:0] == $past(bucket))
    else $error("learn fail missed");
  AST_STATIC_ONLY: assert property (r.st == S_HOST && r.op == OP_WRITE &&
    !r.ents[127] |-> !mem_we) else $error("dynamic host write accepted");
  AST_OPCODE: assert property (r.go && !stop && r.st == S_IDLE && r.op == OP_SEARCH |=>
    r.st == S_SRCH && !r.valid) else $error("search not started");
  AST_GO_DONE: assert property (r.go && r.st == S_IDLE && r.op != OP_SEARCH |->
    ##[1:2] !r.go) else $error("go/done not cleared");
  AST_SEARCH_HOLD: assert property (r.st == S_SWAIT && !rd4 && !stop |=>
    r.st == S_SWAIT && r.valid) else $error("search entry not held");
  AST_STICKY: assert property (r.evt[EVT_WF] && !evt_clr[EVT_WF] |=> r.evt[EVT_WF])
    else $error("event flag dropped");

  COV_SEARCH_HIT: cover property (r.st == S_SRCH ##1 r.st == S_SWAIT);
  COV_LEARN_FAIL: cover property ($rose(r.evt[EVT_LF]));
  COV_ALMOST: cover property ($rose(r.evt[EVT_AF]));
  COV_DA_STATIC: cover property (res_valid && res_static && !r.krsv);
endmodule : malt_table

// ---- verification/malt_ingress_model.sv ----
// Ingress forwarding engine model that issues lookups to the table
`timescale 1ns/1ps
module malt_ingress_model (
  // Clock
  input  wire logic        clk_sys,
  // Lookup request
  output logic             lk_valid,
  input  wire logic        lk_ready,
  output logic             lk_src,
  output logic [47:0]      lk_mac,
  output logic [6:0]       lk_fid,
  output logic [2:0]       lk_port,
  // Other tables' results
  output logic             sta_hit,
  output logic [6:0]       sta_ports,
  output logic             rsv_hit,
  output logic [6:0]       rsv_ports,
  // Lookup result
  input  wire logic        res_valid,
  input  wire logic        res_hit,
  input  wire logic        res_static,
  input  wire logic [6:0]  res_ports
);
  // Idle until the first request
  initial begin
    {lk_valid, lk_src, sta_hit, rsv_hit} = 4'h0;
    {lk_mac, lk_fid, lk_port, sta_ports, rsv_ports} = '0;
  end

  // Hold request until taken; key lines scrambled after so stale keys never match
  task automatic lookup(input logic src, input logic [47:0] mac, input logic [6:0] sp,
                        input logic [1:0] hits, input int gap, output logic [8:0] res,
                        output bit ok);
    int k;
    ok  = 1'b0;
    res = 9'h0;
    repeat (gap + 1) @(posedge clk_sys);
    {lk_valid, lk_src, sta_hit, rsv_hit} <= {1'b1, src, hits[0], hits[1]};
    {lk_mac, sta_ports, rsv_ports, lk_port} <= {mac, sp, ~sp, 3'(gap)};
    for (k = 0; k < 9000; k++) begin
      @(posedge clk_sys);
      if (lk_ready === 1'b1) break;
    end
    lk_valid <= 1'b0;
    lk_mac   <= ~mac;
    for (; k < 9000; k++) begin
      @(posedge clk_sys);
      if (res_valid === 1'b1) begin
        res = {res_hit, res_static, res_ports};
        ok  = 1'b1;
        break;
      end
    end
  endtask : lookup
endmodule : malt_ingress_model

// ---- verification/tb_mac_address_lookup_table.sv ----
// Self-checking bench of the MAC address lookup table
`timescale 1ns/1ps
module tb_mac_address_lookup_table;
  import malt_pkg::*;
  logic        clk_sys  = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [15:0] paddr    = 16'h0;
  logic [31:0] pwdata   = 32'h0;
  logic        age_tick = 1'b0;
  logic        pready, pslverr, lk_valid, lk_ready, lk_src, sta_hit, rsv_hit, re;
  logic        res_valid, res_hit, res_static, res_drop;
  logic [31:0] prdata, rq, acc, seed;
  logic [47:0] lk_mac;
  logic [47:0] key [0:6];
  logic [6:0]  lk_fid, sta_ports, rsv_ports, res_ports;
  logic [2:0]  lk_port;
  logic [9:0]  b0;
  logic [8:0]  res;
  int          err_count = 0;
  int          total_checks = 0;
  int          i, n;

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  malt_table DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .lk_valid(lk_valid), .lk_ready(lk_ready),
    .lk_src(lk_src), .lk_mac(lk_mac), .lk_fid(lk_fid), .lk_port(lk_port),
    .sta_hit(sta_hit), .sta_ports(sta_ports), .rsv_hit(rsv_hit), .rsv_ports(rsv_ports),
    .age_tick(age_tick), .res_valid(res_valid), .res_hit(res_hit),
    .res_static(res_static), .res_drop(res_drop), .res_ports(res_ports)
  );

  malt_ingress_model u_ing (
    .clk_sys(clk_sys), .lk_valid(lk_valid), .lk_ready(lk_ready), .lk_src(lk_src),
    .lk_mac(lk_mac), .lk_fid(lk_fid), .lk_port(lk_port), .sta_hit(sta_hit),
    .sta_ports(sta_ports), .rsv_hit(rsv_hit), .rsv_ports(rsv_ports),
    .res_valid(res_valid), .res_hit(res_hit), .res_static(res_static),
    .res_ports(res_ports)
  );

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt

  // Bucket of a key under hash option 0, filter identifier unused
  function automatic logic [9:0] bkt(input logic [47:0] m);
    return m[9:0] ^ m[19:10] ^ m[29:20] ^ m[39:30] ^ {2'h0, m[47:40]};
  endfunction : bkt

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic finish_test;
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic tmo;
    err_count++;
    $display("BAD %0t wait ran out", $time);
    finish_test();
  endtask : tmo

  // One APB transfer; request held until pready seen at an edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    rq = prdata;
    re = pslverr;
    if (k == 16) tmo();
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [15:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Start a host operation and poll go/done
  task automatic op(input logic [31:0] c);
    int k;
    wr(OFF_ACC, c);
    for (k = 0; k < 40; k++) begin
      rd(OFF_ACC);
      if (rq[ACC_GO] === 1'b0) break;
    end
    if (k == 40) tmo();
  endtask : op

  task automatic hread(input logic [47:0] m);
    wr(OFF_IDX0, m[31:0]);
    wr(OFF_IDX1, {16'h0, m[47:32]});
    op(32'h8000_0002);
  endtask : hread

  task automatic hwrite(input logic [47:0] m, input logic st, input logic [6:0] p);
    wr(OFF_IDX0, m[31:0]);
    wr(OFF_IDX1, {16'h0, m[47:32]});
    wr(OFF_ENT1, {st, 1'b0, p[0], 29'h0});
    wr(OFF_ENT2, {25'h0, p});
    wr(OFF_ENT3, {16'h0, m[47:32]});
    wr(OFF_ENT4, m[31:0]);
    op(32'h8000_0001);
  endtask : hwrite

  task automatic lk(input logic s, input logic [47:0] m, input logic [6:0] sp,
                    input logic [1:0] h);
    bit ok;
    seed = nxt(seed);
    u_ing.lookup(s, m, sp, h, int'(seed[1:0]), res, ok);
    if (!ok) tmo();
  endtask : lk

  // Main sequence
  initial begin
    seed = 32'h37;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(OFF_CTRL);
    check(rq, 32'h0, "ctrl reset");
    rd(OFF_EVT);
    check(rq, 32'h0, "event reset");
    rd(16'h0408);
    check(32'(re), 32'h1, "unmapped");
    // Six keys in one bucket, one elsewhere
    n = 0;
    for (i = 0; i < 200000 && n < 7; i++) begin
      seed = nxt(seed);
      key[n] = {16'h0200, seed};
      if (n == 0) b0 = bkt(key[0]);
      if ((n < 6) == (bkt(key[n]) === b0)) n++;
    end
    if (n < 7) tmo();
    repeat (4100) @(posedge clk_sys);
    // Static fill: almost full on third and fourth, fail on fifth
    for (i = 0; i < 5; i++) begin
      hwrite(key[i], 1'b1, 7'(i + 1));
      rd(OFF_EVT);
      check(32'(rq[2:0]), (i < 2) ? 32'h0 : (i < 4) ? 32'h1 : 32'h3, "event");
      rd(OFF_IDX0);
      if (i == 4) check(32'(rq[9:0]), 32'(b0), "fail index");
      if (i == 2 || i == 3) begin
        wr(OFF_IDX0, 32'(rq[11:0]));
        op(32'h8000_000a);
        rd(OFF_ENT4);
        check(rq, key[i][31:0], "direct read");
      end
      hread(key[i]);
      check(32'(rq[30]), 32'(i < 4), "found");
      rd(OFF_ENT2);
      check(rq, (i < 4) ? 32'(i + 1) : 32'h0, "ports");
    end
    hwrite(key[6], 1'b0, 7'h7f);
    hread(key[6]);
    check(32'(rq[30]), 32'h0, "dynamic write");
    wr(OFF_EVT, 32'h7);
    rd(OFF_EVT);
    check(rq, 32'h0, "event clear");
    lk(1'b0, key[1], 7'h50, 2'b01);
    check(32'(res), 32'h182, "static da");
    check(32'(res_drop), 32'h0, "no drop");
    lk(1'b0, key[1], 7'h50, 2'b10);
    check(32'(res[6:0]), 32'h2f, "reserved");
    lk(1'b1, key[5], 7'h0, 2'b00);
    rd(OFF_EVT);
    check(rq, 32'h4, "learn fail");
    rd(OFF_IDX1);
    check(32'(rq[9:0]), 32'(b0), "learn index");
    lk(1'b1, key[6], 7'h0, 2'b00);
    lk(1'b0, key[6], 7'h0, 2'b00);
    check(32'(res[8:7]), 32'h2, "dynamic da");
    lk(1'b0, key[6], 7'h31, 2'b01);
    check(32'(res[6:0]), 32'h31, "static over dynamic");
    for (i = 0; i < 8; i++) begin
      seed = nxt(seed);
      lk(1'b0, {16'h0300, seed}, 7'h0, 2'b00);
      check(32'(res[8]), 32'h0, "miss");
    end
    // Eight sweeps age out the learned key; statics stay
    wr(OFF_CTRL, 32'h8);
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      age_tick <= 1'b1;
      @(posedge clk_sys);
      age_tick <= 1'b0;
      lk(1'b0, 48'h0300_0000_0000, 7'h0, 2'b00);
    end
    lk(1'b0, key[6], 7'h0, 2'b00);
    check(32'(res[8]), 32'h0, "aged out");
    lk(1'b0, key[0], 7'h0, 2'b00);
    check(32'(res), 32'h181, "static kept");
    check(32'(res_drop), 32'h1, "drop");
    // Search returns the four statics, entry 4 read resumes it
    wr(OFF_ACC, 32'h8000_0003);
    n = 0;
    for (i = 0; i < 9000; i++) begin
      rd(OFF_ACC);
      acc = rq;
      if (acc[30] === 1'b1) begin
        n++;
        rd(OFF_ENT1);
        rd(OFF_ENT2);
        rd(OFF_ENT3);
        rd(OFF_ENT4);
      end
      if (acc[ACC_GO] === 1'b0) break;
    end
    if (i == 9000) tmo();
    check(32'(n), 32'h4, "search count");
    check(32'(acc[28:16]), 32'h4, "valid count");
    // Host and ingress follow the same hash option
    wr(OFF_CTRL, 32'h1);
    key[5] = {16'h0300, nxt(seed)};
    hwrite(key[5], 1'b1, 7'h44);
    lk(1'b0, key[5], 7'h0, 2'b00);
    check(32'(res), 32'h1c4, "hash option");
    finish_test();
  end
endmodule : tb_mac_address_lookup_table
